// ---- common/ewp_pkg.sv ----
// Shared constants and types for the serial EEPROM write-protect controller
package ewp_pkg;

  // Frame layout: start bit, opcode, address, optional data word
  localparam int OP_W       = 2;
  localparam int ADR_W      = 8;
  localparam int LOC_W      = 7;
  localparam int DATA_W     = 16;
  localparam int BOUND_W    = 8;
  localparam int HDR_BITS   = OP_W + ADR_W;
  localparam int FRAME_BITS = HDR_BITS + DATA_W;

  // Opcodes
  localparam logic [1:0] OP_CTRL  = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [1:0] OP_CLEAR = 2'h3;

  // Two top address bits that select a control command under OP_CTRL
  localparam logic [1:0] SUB_DIS   = 2'h0;
  localparam logic [1:0] SUB_ALL   = 2'h1;
  localparam logic [1:0] SUB_ENA   = 2'h3;

  // Protect register values
  localparam logic [7:0] BOUND_CLEAR = 8'hFF;
  localparam logic [7:0] CLEAR_ADR   = 8'hFF;

  // Timing: programming time in microseconds, clock 10 MHz
  localparam int CLK_HZ        = 10_000_000;
  localparam int PROG_TIME_US  = 10_000;
  localparam int PROG_CYCLES   = PROG_TIME_US * (CLK_HZ / 1_000_000);

  // Structure
  localparam int SYNC_PINS  = 5;
  localparam int FIFO_DEPTH = 8;
  localparam int CMD_W      = 1 + LOC_W + DATA_W;

  // Pin positions in the synchroniser vector
  localparam int PIN_CS  = 4;
  localparam int PIN_SK  = 3;
  localparam int PIN_SI  = 2;
  localparam int PIN_PA  = 1;
  localparam int PIN_PS  = 0;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_READ  = 3'b100
  } ewp_frame_t;

endpackage

// ---- common/ewp_fifo_if.sv ----
// Carrier between the controller and its command FIFO
`timescale 1ns/10ps
interface ewp_fifo_if #(
  parameter int WIDTH = 24
);
  logic             push_valid;
  logic             push_ready;
  logic [WIDTH-1:0] push_data;
  logic             pop_valid;
  logic             pop_ready;
  logic [WIDTH-1:0] pop_data;

  modport src (
    output push_valid,
    output push_data,
    input  push_ready,
    input  pop_valid,
    input  pop_data,
    output pop_ready
  );

  modport store (
    input  push_valid,
    input  push_data,
    output push_ready,
    output pop_valid,
    output pop_data,
    input  pop_ready
  );
endinterface

// ---- verilog/ewp_fifo.sv ----
// Command FIFO holding array programming requests
`timescale 1ns/10ps
module ewp_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input  wire logic clk,
  input  wire logic rst_n,
  ewp_fifo_if.store f
);
  localparam int AW = $clog2(DEPTH);

  // Pointer arithmetic relies on a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("ewp_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;
  logic             full_w;
  logic             empty_w;
  logic             push_w;
  logic             pop_w;

  // Extra pointer bit tells full from empty
  assign empty_w      = (wr_ptr_r == rd_ptr_r);
  assign full_w       = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                        (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign push_w       = f.push_valid & ~full_w;
  assign pop_w        = f.pop_ready & ~empty_w;
  assign f.push_ready = ~full_w;
  assign f.pop_valid  = ~empty_w;
  assign f.pop_data   = mem_r[rd_ptr_r[AW-1:0]];

  // Storage is plain flops, no reset needed on data
  always_ff @(posedge clk) begin
    if (push_w) begin
      mem_r[wr_ptr_r[AW-1:0]] <= f.push_data;
    end
  end

  // Pointers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push_w) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop_w) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end
endmodule // ewp_fifo

// ---- verilog/ewp_ctrl.sv ----
// Instruction control for a 128 x 16 serial EEPROM with write-protect boundary
//
// Operation
// - After power-up the latch is clear; every programming command is refused.
// - The write-enable latch stays set until write-disable or power loss.
// - Write-enable frame sets the latch at chip-select fall, protect-select low.
// - Word write needs latch set, address below boundary, program pin high, select low.
// - Chip-select fall right after the last data bit starts self-timed programming.
// - During programming time report busy and accept no instruction.
// - With chip select high, data-out shows 0 while busy, 1 when ready.
// - Status appears on data-out without any serial clock edges.
// - Write-all programs every location with the frame data, timed like a write.
// - Write-all needs cleared boundary, latch set, program pin high, select low.
// - Write-disable frame clears the latch at chip-select fall.
// - Array reads run whether or not the latch is set; this controller implements only the boundary read.
// - Boundary register is 8 bits; locations at or above it are protected.
// - Boundary read shifts dummy 0 then 8 bits MSB first on serial clock rise.
// - Only the low 7 boundary bits count as an address.
// - Protect-unlock needs latch set and both pins high; arms at chip-select fall.
// - Unlock must directly precede protect clear; any other instruction disarms it.
// - Protect-clear programs the boundary to all ones, freeing every location.
// - Protect-clear needs fresh unlock and both pins high.
// - Chip-select fall after the last clear address bit starts a timed clear.
// - Frames open with start bit 1, 2-bit opcode, 8 address bits, sampled on rise.
// - Only the low 7 address bits select a location; the top bit is ignored.
// - Write and write-all carry 16 data bits after the address, MSB first.
// - Write-enable is opcode 00 with both top address bits 1.
`timescale 1ns/10ps
module ewp_ctrl #(
  parameter int          PROG_CYCLES = ewp_pkg::PROG_CYCLES,
  parameter int          FIFO_DEPTH  = ewp_pkg::FIFO_DEPTH,
  parameter logic [7:0]  BOUND_RESET = ewp_pkg::BOUND_CLEAR
) (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        chip_select,
  input  wire logic                        serial_clock,
  input  wire logic                        serial_in,
  input  wire logic                        program_allow_pin,
  input  wire logic                        protect_sel_pin,
  output logic                             data_out,
  output logic                             data_out_oe,
  output logic                             arr_wr_valid,
  input  wire logic                        arr_wr_ready,
  output logic                             arr_wr_all,
  output logic [ewp_pkg::LOC_W-1:0]        arr_wr_addr,
  output logic [ewp_pkg::DATA_W-1:0]       arr_wr_data,
  output logic                             write_enabled,
  output logic                             prog_busy,
  output logic [ewp_pkg::BOUND_W-1:0]      write_protect_boundary
);
  localparam int TW = $clog2(PROG_CYCLES + 1);
  localparam int NP = ewp_pkg::SYNC_PINS;

  // Timer and FIFO sizes must be servable
  if (PROG_CYCLES < 1) begin : g_bad_prog
    $error("ewp_ctrl: PROG_CYCLES must be at least 1");
  end
  if (FIFO_DEPTH < 2) begin : g_bad_fifo
    $error("ewp_ctrl: FIFO_DEPTH must be at least 2");
  end

  // Control command match: opcode 00 and the two top address bits
  function automatic logic ewp_is_ctrl(input logic [1:0] op,
                                       input logic [7:0] adr,
                                       input logic [1:0] sub);
    ewp_is_ctrl = (op == ewp_pkg::OP_CTRL) && (adr[7:6] == sub);
  endfunction

  // Reset synchroniser
  logic [1:0] rst_sr_r;
  logic       rst_sync_n;

  // Pin synchronisers
  logic [NP-1:0] pin_in_w;
  logic [NP-1:0] meta_r;
  logic [NP-1:0] sync_r;
  logic          cs_s;
  logic          sk_s;
  logic          si_s;
  logic          pa_s;
  logic          ps_s;
  logic          sk_d_r;
  logic          cs_d_r;
  logic          sk_rise;
  logic          cs_fall;

  // Frame state
  ewp_pkg::ewp_frame_t                 state_r;
  logic [4:0]                          bits_r;
  logic [ewp_pkg::FRAME_BITS-1:0]      sr_r;
  logic [ewp_pkg::BOUND_W:0]           out_sr_r;
  logic                                seen_r;

  // Device state
  logic                                wel_r;
  logic                                armed_r;
  logic [ewp_pkg::BOUND_W-1:0]         bound_r;
  logic [TW-1:0]                       tmr_r;
  logic                                clr_pend_r;
  logic                                show_r;
  logic                                do_r;
  logic                                oe_r;

  // Decode wires
  logic                                busy_w;
  logic                                hdr_w;
  logic                                full_w;
  logic [1:0]                          op_w;
  logic [7:0]                          adr_w;
  logic [ewp_pkg::DATA_W-1:0]          dat_w;
  logic                                prot_w;
  logic                                exec_w;
  logic                                start_w;
  logic                                rd_hdr_w;
  logic                                is_en;
  logic                                is_dis;
  logic                                is_wr;
  logic                                is_all;
  logic                                is_unl;
  logic                                is_clr;
  logic                                arr_go;
  logic                                prog_go;

  ewp_fifo_if #(.WIDTH(ewp_pkg::CMD_W)) fq ();

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sr_r <= 2'h0;
    end else begin
      rst_sr_r <= {rst_sr_r[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_sr_r[1];

  // Every pin is asynchronous to clk; two flops each
  assign pin_in_w = {chip_select, serial_clock, serial_in, program_allow_pin, protect_sel_pin};
  for (genvar i = 0; i < NP; i++) begin : g_sync
    always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        meta_r[i] <= 1'b0;
        sync_r[i] <= 1'b0;
      end else begin
        meta_r[i] <= pin_in_w[i];
        sync_r[i] <= meta_r[i];
      end
    end
  end

  assign cs_s = sync_r[ewp_pkg::PIN_CS];
  assign sk_s = sync_r[ewp_pkg::PIN_SK];
  assign si_s = sync_r[ewp_pkg::PIN_SI];
  assign pa_s = sync_r[ewp_pkg::PIN_PA];
  assign ps_s = sync_r[ewp_pkg::PIN_PS];

  // Edge detectors look only at the second stage
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sk_d_r <= 1'b0;
      cs_d_r <= 1'b0;
    end else begin
      sk_d_r <= sk_s;
      cs_d_r <= cs_s;
    end
  end
  assign sk_rise = sk_s & ~sk_d_r & cs_s;
  assign cs_fall = ~cs_s & cs_d_r;

  // Field extraction depends on how many bits the frame carried
  assign busy_w   = (tmr_r != '0);
  assign hdr_w    = (bits_r == 5'(ewp_pkg::HDR_BITS));
  assign full_w   = (bits_r == 5'(ewp_pkg::FRAME_BITS));
  assign op_w     = full_w ? sr_r[25:24] : sr_r[9:8];
  assign adr_w    = full_w ? sr_r[23:16] : sr_r[7:0];
  assign dat_w    = sr_r[15:0];
  // Boundary all ones means nothing is protected, so 0x7F stays writable
  assign prot_w   = (bound_r != ewp_pkg::BOUND_CLEAR) &&
                    (adr_w[6:0] >= bound_r[6:0]);

  // A start bit is only taken while idle and not programming
  assign start_w  = (state_r == ewp_pkg::ST_IDLE) & sk_rise & si_s & ~busy_w;
  // Boundary read goes out once the tenth bit lands; it is not gated by the latch
  assign rd_hdr_w = (state_r == ewp_pkg::ST_SHIFT) & sk_rise & (bits_r == 5'd9) &
                    (sr_r[8:7] == ewp_pkg::OP_READ) & ps_s;

  // Commands execute on chip-select fall; exact bit counts stop overrun frames
  assign exec_w = cs_fall & seen_r & ~busy_w;
  assign is_en  = exec_w & hdr_w & ewp_is_ctrl(op_w, adr_w, ewp_pkg::SUB_ENA) & ~ps_s;
  assign is_dis = exec_w & hdr_w & ewp_is_ctrl(op_w, adr_w, ewp_pkg::SUB_DIS) & ~ps_s;
  assign is_wr  = exec_w & full_w & (op_w == ewp_pkg::OP_WRITE) & ~ps_s & pa_s &
                  wel_r & ~prot_w;
  assign is_all = exec_w & full_w & ewp_is_ctrl(op_w, adr_w, ewp_pkg::SUB_ALL) & ~ps_s &
                  pa_s & wel_r & (bound_r == ewp_pkg::BOUND_CLEAR);
  assign is_unl = exec_w & hdr_w & ewp_is_ctrl(op_w, adr_w, ewp_pkg::SUB_ENA) & ps_s &
                  pa_s & wel_r;
  assign is_clr = exec_w & hdr_w & (op_w == ewp_pkg::OP_CLEAR) &
                  (adr_w == ewp_pkg::CLEAR_ADR) & ps_s & pa_s & armed_r;
  // A full FIFO refuses the command outright rather than losing it later
  assign arr_go  = (is_wr | is_all) & fq.push_ready;
  assign prog_go = arr_go | is_clr;

  // Request handed to the array side
  assign fq.push_valid = arr_go;
  assign fq.push_data  = {is_all, adr_w[6:0], dat_w};
  assign fq.pop_ready  = arr_wr_ready;
  assign arr_wr_valid  = fq.pop_valid;
  assign arr_wr_all    = fq.pop_data[ewp_pkg::CMD_W-1];
  assign arr_wr_addr   = fq.pop_data[ewp_pkg::CMD_W-2:ewp_pkg::DATA_W];
  assign arr_wr_data   = fq.pop_data[ewp_pkg::DATA_W-1:0];

  ewp_fifo #(
    .WIDTH (ewp_pkg::CMD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .f     (fq)
  );

  // Frame sequencer; chip select low always returns to idle
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_r <= ewp_pkg::ST_IDLE;
    end else if (!cs_s) begin
      state_r <= ewp_pkg::ST_IDLE;
    end else begin
      case (state_r)
        ewp_pkg::ST_IDLE: begin
          if (start_w) begin
            state_r <= ewp_pkg::ST_SHIFT;
          end
        end
        ewp_pkg::ST_SHIFT: begin
          if (rd_hdr_w) begin
            state_r <= ewp_pkg::ST_READ;
          end
        end
        ewp_pkg::ST_READ: begin
          state_r <= ewp_pkg::ST_READ;
        end
        default: begin
          state_r <= ewp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Bit collection; the count saturates so long frames never alias a valid length
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bits_r <= 5'h00;
      sr_r   <= '0;
    end else if (start_w) begin
      bits_r <= 5'h00;
      sr_r   <= '0;
    end else if (sk_rise && state_r != ewp_pkg::ST_IDLE) begin
      sr_r   <= {sr_r[ewp_pkg::FRAME_BITS-2:0], si_s};
      bits_r <= (bits_r == 5'h1F) ? bits_r : bits_r + 5'h01;
    end
  end

  // Frame-seen flag survives the chip-select fall cycle so exec can use it
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      seen_r <= 1'b0;
    end else if (start_w) begin
      seen_r <= 1'b1;
    end else if (!cs_s) begin
      seen_r <= 1'b0;
    end
  end

  // Boundary read shifter: dummy zero then MSB first, one bit per rising edge
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      out_sr_r <= '0;
    end else if (rd_hdr_w) begin
      out_sr_r <= {1'b0, bound_r};
    end else if (sk_rise && state_r == ewp_pkg::ST_READ) begin
      out_sr_r <= {out_sr_r[ewp_pkg::BOUND_W-1:0], 1'b0};
    end
  end

  // Write-enable latch: clear at power-up, changed only by its two commands
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wel_r <= 1'b0;
    end else if (is_en) begin
      wel_r <= 1'b1;
    end else if (is_dis) begin
      wel_r <= 1'b0;
    end
  end

  // Unlock is armed by its own frame and disarmed by any other instruction
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      armed_r <= 1'b0;
    end else if (exec_w) begin
      armed_r <= is_unl;
    end
  end

  // Programming timer; busy lasts the whole programming time
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tmr_r <= '0;
    end else if (prog_go) begin
      tmr_r <= TW'(PROG_CYCLES);
    end else if (busy_w) begin
      tmr_r <= tmr_r - 1'b1;
    end
  end

  // Boundary is rewritten when the timed clear ends
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      clr_pend_r <= 1'b0;
      bound_r    <= BOUND_RESET;
    end else if (is_clr) begin
      clr_pend_r <= 1'b1;
    end else if (clr_pend_r && tmr_r == TW'(1)) begin
      clr_pend_r <= 1'b0;
      bound_r    <= ewp_pkg::BOUND_CLEAR;
    end
  end

  // Status display after programming, dropped by a start bit once ready
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      show_r <= 1'b0;
    end else if (prog_go) begin
      show_r <= 1'b1;
    end else if (sk_rise && si_s && !busy_w) begin
      show_r <= 1'b0;
    end
  end

  // Data-out pin: status needs no serial clock, read data follows the shifter
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      do_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      oe_r <= cs_s & (show_r | state_r == ewp_pkg::ST_READ);
      do_r <= show_r ? ~busy_w : out_sr_r[ewp_pkg::BOUND_W];
    end
  end

  assign data_out               = do_r;
  assign data_out_oe            = oe_r;
  assign write_enabled          = wel_r;
  assign prog_busy              = busy_w;
  assign write_protect_boundary = bound_r;
endmodule // ewp_ctrl

// ---- verif/ewp_ctrl_sva.sv ----
// Port checker for the serial EEPROM write-protect controller
`timescale 1ns/10ps
module ewp_ctrl_sva #(
  parameter int PROG_CYCLES = 20
) (
  input wire logic                         clk,
  input wire logic                         rst_n,
  input wire logic                         chip_select,
  input wire logic                         program_allow_pin,
  input wire logic                         protect_sel_pin,
  input wire logic                         data_out,
  input wire logic                         data_out_oe,
  input wire logic                         arr_wr_valid,
  input wire logic                         arr_wr_ready,
  input wire logic                         arr_wr_all,
  input wire logic [ewp_pkg::LOC_W-1:0]    arr_wr_addr,
  input wire logic [ewp_pkg::DATA_W-1:0]   arr_wr_data,
  input wire logic                         write_enabled,
  input wire logic                         prog_busy,
  input wire logic [ewp_pkg::BOUND_W-1:0]  write_protect_boundary
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  int busy_cnt_r;
  int busy_cnt_nxt;
  // Length of the busy window, so its exact span can be judged at the end
  assign busy_cnt_nxt = prog_busy ? busy_cnt_r + 1 : 0;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) busy_cnt_r <= 0;
    else busy_cnt_r <= busy_cnt_nxt;
  end
  // Steps: deselected long enough, and ready seen with select still high
  sequence s_desel;
    !chip_select [*5];
  endsequence
  sequence s_ready_seen;
    $fell(prog_busy) && chip_select ##1 chip_select [*3];
  endsequence
  property p_busy_len;
    $fell(prog_busy) |-> busy_cnt_r == PROG_CYCLES;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy span wrong");
  property p_status_busy;
    data_out_oe && prog_busy && $past(prog_busy, 2) |-> !data_out;
  endproperty
  a_status_busy: assert property (p_status_busy) else $error("busy not low");
  property p_status_ready;
    s_ready_seen |-> data_out_oe && data_out;
  endproperty
  a_status_ready: assert property (p_status_ready) else $error("ready not high");
  property p_oe_off;
    s_desel |-> !data_out_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("driven while deselected");
  property p_wen_set;
    $rose(write_enabled) |-> !chip_select && !protect_sel_pin;
  endproperty
  a_wen_set: assert property (p_wen_set) else $error("latch set oddly");
  property p_wen_clr;
    $fell(write_enabled) |-> !chip_select;
  endproperty
  a_wen_clr: assert property (p_wen_clr) else $error("latch lost");
  property p_req_ok;
    $rose(arr_wr_valid) |-> write_enabled && program_allow_pin && !protect_sel_pin;
  endproperty
  a_req_ok: assert property (p_req_ok) else $error("write not allowed");
  property p_all_clear;
    $rose(arr_wr_valid) && arr_wr_all |-> write_protect_boundary == ewp_pkg::BOUND_CLEAR;
  endproperty
  a_all_clear: assert property (p_all_clear) else $error("write-all protected");
  property p_busy_start;
    $rose(prog_busy) |-> !chip_select && program_allow_pin;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy start wrong");
  property p_hold;
    arr_wr_valid && !arr_wr_ready |=> arr_wr_valid && $stable(arr_wr_addr)
      && $stable(arr_wr_data);
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped");
endmodule // ewp_ctrl_sva
bind ewp_ctrl ewp_ctrl_sva #(.PROG_CYCLES(PROG_CYCLES)) u_ewp_ctrl_sva (.clk, .rst_n,
  .chip_select, .program_allow_pin, .protect_sel_pin, .data_out, .data_out_oe, .arr_wr_valid,
  .arr_wr_ready, .arr_wr_all, .arr_wr_addr, .arr_wr_data, .write_enabled, .prog_busy,
  .write_protect_boundary);

// ---- verif/ewp_master_model.sv ----
// Behavioural serial bus master on the far side of the controller
`timescale 1ns/10ps
module ewp_master_model (
  input  wire logic clk,
  input  wire logic data_out,
  input  wire logic data_out_oe,
  output logic      chip_select,
  output logic      serial_clock,
  output logic      serial_in,
  output logic      program_allow_pin,
  output logic      protect_sel_pin
);
  logic [8:0] cap;
  logic       line_w;
  // A released data line reads as the inverse of its last level, so a missing enable shows up
  assign line_w = data_out_oe ? data_out : ~data_out;
  // Serial clock stands still low between frames
  initial begin
    chip_select = 1'b0;
    serial_clock = 1'b0;
    serial_in = 1'b1;
    program_allow_pin = 1'b0;
    protect_sel_pin = 1'b0;
    cap = 9'h000;
  end
  // Levels last 4 clocks since the device samples pins through synchronisers
  task automatic send(input logic [26:0] f, input int n, input logic pa, input logic ps);
    @(negedge clk);
    program_allow_pin = pa;
    protect_sel_pin = ps;
    chip_select = 1'b1;
    repeat (4) @(negedge clk);
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = f[i];
      repeat (4) @(negedge clk);
      serial_clock = 1'b1;
      repeat (4) @(negedge clk);
      serial_clock = 1'b0;
      repeat (4) @(negedge clk);
      cap = {cap[7:0], line_w};
    end
    chip_select = 1'b0;
    serial_in = ~serial_in;
    repeat (8) @(negedge clk);
  endtask
  // Status poll without clock edges; no new frame until ready is seen
  task automatic poll(output logic first, output int t);
    chip_select = 1'b1;
    repeat (6) @(negedge clk);
    first = line_w;
    for (t = 0; t < 600 && !(data_out_oe === 1'b1 && data_out === 1'b1); t++) @(negedge clk);
    repeat (6) @(negedge clk);
    chip_select = 1'b0;
    repeat (8) @(negedge clk);
  endtask
endmodule // ewp_master_model

// ---- verif/ewp_ctrl_tb.sv ----
// Self-checking bench for the write-protect controller
`timescale 1ns/10ps
module ewp_ctrl_tb;
  localparam int PC = 400;
  logic                        clk, rst_n, arr_rdy, do_w, oe_w, vld, all_w, we_w, busy_w, first;
  wire logic                   cs_w, sk_w, si_w, pa_w, ps_w;
  logic [ewp_pkg::LOC_W-1:0]   adr_w;
  logic [ewp_pkg::DATA_W-1:0]  dat_w;
  logic [ewp_pkg::BOUND_W-1:0] bnd_w;
  int                          err_count, num_checks, t;
  // Free-running 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Boundary starts below the top so protection is exercised before the clear
  ewp_ctrl #(.PROG_CYCLES(PC), .BOUND_RESET(8'hFE)) u_ewp_ctrl (.clk(clk), .rst_n(rst_n),
    .chip_select(cs_w), .serial_clock(sk_w), .serial_in(si_w), .program_allow_pin(pa_w),
    .protect_sel_pin(ps_w), .data_out(do_w), .data_out_oe(oe_w), .arr_wr_valid(vld),
    .arr_wr_ready(arr_rdy), .arr_wr_all(all_w), .arr_wr_addr(adr_w), .arr_wr_data(dat_w),
    .write_enabled(we_w), .prog_busy(busy_w), .write_protect_boundary(bnd_w));
  ewp_master_model u_ewp_master_model (.clk(clk), .data_out(do_w), .data_out_oe(oe_w),
    .chip_select(cs_w), .serial_clock(sk_w), .serial_in(si_w), .program_allow_pin(pa_w),
    .protect_sel_pin(ps_w));
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    if (err_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d, input logic pa);
    u_ewp_master_model.send({1'b1, ewp_pkg::OP_WRITE, a, d}, 27, pa, 1'b0);
  endtask
  task cmd(input logic [1:0] op, input logic [7:0] a, input logic pa, input logic ps);
    u_ewp_master_model.send({16'h0000, 1'b1, op, a}, 11, pa, ps);
  endtask
  // A hung busy window counts as a mismatch and closes the run; spent is busy time already used
  task poll_ok(input int spent);
    u_ewp_master_model.poll(first, t);
    chk(16'(first), 16'h0000);
    chk(16'(t > PC - 60 - spent && t < PC - spent), 16'h0001);
    if (t >= 600) begin
      err_count++;
      report_and_stop;
    end
  endtask
  // Main sequence
  initial begin
    rst_n = 1'b0;
    arr_rdy = 1'b0;
    err_count = 0;
    num_checks = 0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    chk(16'({we_w, busy_w}), 16'h0000);
    chk(16'(bnd_w), 16'h00FE);
    wr(8'h05, 16'h1234, 1'b1);
    chk(16'({busy_w, vld}), 16'h0000);
    cmd(ewp_pkg::OP_CTRL, {ewp_pkg::SUB_ENA, 6'h15}, 1'b0, 1'b0);
    chk(16'(we_w), 16'h0001);
    wr(8'h05, 16'h1234, 1'b0);
    chk(16'(busy_w), 16'h0000);
    // Fill the FIFO while stalled; the ninth write finds it full
    for (int k = 0; k < 9; k++) begin
      wr({1'b1, 7'(7'h70 + k)}, 16'(16'hA5A0 + k), 1'b1);
      chk(16'(busy_w), 16'(k < 8));
      if (k == 0) begin
        cmd(ewp_pkg::OP_CTRL, {ewp_pkg::SUB_DIS, 6'h00}, 1'b0, 1'b0);
        chk(16'(we_w), 16'h0001);
      end
      // The disable frame above is 145 clocks of the first busy window
      if (k < 8) poll_ok(k == 0 ? 145 : 0);
    end
    arr_rdy = 1'b1;
    for (int k = 0; k < 8; k++) begin
      chk(16'(vld), 16'h0001);
      chk(16'(adr_w), 16'(7'h70 + k));
      chk(dat_w, 16'(16'hA5A0 + k));
      @(negedge clk);
    end
    chk(16'(vld), 16'h0000);
    // Protected location and write-all are both refused before the clear
    wr(8'hFE, 16'h0001, 1'b1);
    chk(16'({busy_w, vld}), 16'h0000);
    u_ewp_master_model.send({1'b1, ewp_pkg::OP_CTRL, ewp_pkg::SUB_ALL, 6'h2A, 16'h5AC3}, 27,
      1'b1, 1'b0);
    chk(16'({busy_w, vld}), 16'h0000);
    u_ewp_master_model.send({8'h00, 1'b1, ewp_pkg::OP_READ, 16'h0000}, 19, 1'b0, 1'b1);
    chk(16'(u_ewp_master_model.cap), 16'h00FE);
    // Clear needs an unlock directly before it
    cmd(ewp_pkg::OP_CLEAR, ewp_pkg::CLEAR_ADR, 1'b1, 1'b1);
    chk(16'(busy_w), 16'h0000);
    cmd(ewp_pkg::OP_CTRL, {ewp_pkg::SUB_ENA, 6'h00}, 1'b1, 1'b1);
    cmd(ewp_pkg::OP_READ, 8'h00, 1'b1, 1'b1);
    cmd(ewp_pkg::OP_CLEAR, ewp_pkg::CLEAR_ADR, 1'b1, 1'b1);
    chk(16'(busy_w), 16'h0000);
    cmd(ewp_pkg::OP_CTRL, {ewp_pkg::SUB_ENA, 6'h00}, 1'b1, 1'b1);
    cmd(ewp_pkg::OP_CLEAR, ewp_pkg::CLEAR_ADR, 1'b1, 1'b1);
    chk(16'(busy_w), 16'h0001);
    poll_ok(0);
    chk(16'(bnd_w), 16'h00FF);
    // Write-all held at the stalled array port for inspection
    arr_rdy = 1'b0;
    u_ewp_master_model.send({1'b1, ewp_pkg::OP_CTRL, ewp_pkg::SUB_ALL, 6'h2A, 16'h5AC3}, 27,
      1'b1, 1'b0);
    chk(16'({vld, all_w}), 16'h0003);
    chk(dat_w, 16'h5AC3);
    poll_ok(0);
    arr_rdy = 1'b1;
    cmd(ewp_pkg::OP_CTRL, {ewp_pkg::SUB_DIS, 6'h3F}, 1'b0, 1'b0);
    chk(16'(we_w), 16'h0000);
    wr(8'h01, 16'hFFFF, 1'b1);
    chk(16'(busy_w), 16'h0000);
    report_and_stop;
  end
endmodule // ewp_ctrl_tb
